// *** hw/rsh_pkg.sv ***
// Shared constants for the reluctance sensor hysteresis and filter block.
package rsh_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_MIN_NS = 2500;
  localparam int FILT_START_NS = 125000;
  localparam int PERIOD_MIN_NS = 80000;
  localparam int PERIOD_SAT_NS = 4000000;
  localparam int FILT_MIN_CYC = FILT_MIN_NS / CLK_PERIOD_NS;
  localparam int FILT_START_CYC = FILT_START_NS / CLK_PERIOD_NS;
  localparam int PERIOD_MIN_CYC = PERIOD_MIN_NS / CLK_PERIOD_NS;
  localparam int PERIOD_SAT_CYC = PERIOD_SAT_NS / CLK_PERIOD_NS;
  localparam int FILT_DIV_SHIFT = 5;
  localparam int CNT_W = 18;

  // ---------------------------------------------------------------------
  // Hysteresis levels, HI1 to HI5 coded 0 to 4
  // ---------------------------------------------------------------------
  localparam logic [2:0] HYST_LVL_1 = 3'h0;
  localparam logic [2:0] HYST_LVL_3 = 3'h2;
  localparam logic [2:0] HYST_LVL_5 = 3'h4;
  localparam int PEAK_THR_N = 4;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_FILTER = 8'h0C;

  // ---------------------------------------------------------------------
  // Configuration register fields
  // ---------------------------------------------------------------------
  localparam int CFG_W = 10;
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam int CFG_ARCH_SELECT = 0;
  localparam int CFG_HYST_ADAPT = 1;
  localparam int CFG_FILTER_EN = 2;
  localparam int CFG_HYST_LSB = 3;
  localparam int CFG_HYST_MSB = 5;
  localparam int CFG_PEAK_FB = 6;
  localparam int CFG_FE_FILTER = 7;
  localparam int CFG_SECOND_EDGE = 8;
  localparam int CFG_MIN_FORCE = 9;

  // ---------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------
  localparam int ST_PULSE = 0;
  localparam int ST_HYST_ON = 1;
  localparam int ST_LVL_LSB = 2;
  localparam int ST_LVL_MSB = 4;
  localparam int ST_COMP = 5;
  localparam int ST_PEAK_LSB = 6;
  localparam int ST_PEAK_MSB = 8;
  localparam int ST_PEAK_VALID = 9;

endpackage : rsh_pkg

// *** hw/rsh_period_meter.sv ***
// Period meter counting clock cycles between rising output edges.
`timescale 1ns/10ps

module rsh_period_meter #(
  parameter int CNT_W = rsh_pkg::CNT_W,
  parameter int SAT_CYC = rsh_pkg::PERIOD_SAT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic rise_i,
  output logic [CNT_W-1:0] period_o,
  output logic valid_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic armed;
  logic next_armed;
  logic [CNT_W-1:0] next_period;
  logic next_valid;

  // The first edge only arms the meter; saturation caps very slow wheels.
  always_comb begin
    next_cnt = cnt;
    next_armed = armed;
    next_period = period_o;
    next_valid = 1'b0;
    if (rise_i) begin
      next_cnt = CNT_W'(1);
      next_armed = 1'b1;
      if (armed) begin
        next_period = cnt;
        next_valid = 1'b1;
      end
    end else if (cnt < CNT_W'(SAT_CYC)) begin
      next_cnt = cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      armed <= 1'b0;
      period_o <= '0;
      valid_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      armed <= next_armed;
      period_o <= next_period;
      valid_o <= next_valid;
    end
  end

endmodule : rsh_period_meter

// *** hw/rsh_edge_filter.sv ***
// Edge filter shaping the comparator output into the sensor pulse.
`timescale 1ns/10ps

module rsh_edge_filter #(
  parameter int CNT_W = rsh_pkg::CNT_W
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic raw_i,
  input wire logic en_i,
  input wire logic fe_stable_i,
  input wire logic [CNT_W-1:0] filt_cyc_i,
  output logic out_o
);

  typedef enum logic [1:0] {ST_LOW, ST_HIGH, ST_BLANK} rsh_filt_state_t;

  rsh_filt_state_t state;
  rsh_filt_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] cnt_inc;

  assign cnt_inc = cnt + CNT_W'(1);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!en_i) begin
      next_state = raw_i ? ST_HIGH : ST_LOW;
      next_cnt = '0;
    end else begin
      unique case (state)
        ST_LOW: begin
          // Rise only once the input has stayed high beyond the filter time.
          if (!raw_i) begin
            next_cnt = '0;
          end else if (cnt >= filt_cyc_i) begin
            next_state = ST_HIGH;
            next_cnt = '0;
          end else begin
            next_cnt = cnt_inc;
          end
        end
        ST_HIGH: begin
          if (fe_stable_i) begin
            if (raw_i) begin
              next_cnt = '0;
            end else if (cnt_inc >= filt_cyc_i) begin
              next_state = ST_LOW;
              next_cnt = '0;
            end else begin
              next_cnt = cnt_inc;
            end
          end else if (!raw_i) begin
            next_state = ST_BLANK;
            next_cnt = '0;
          end
        end
        ST_BLANK: begin
          // Input is ignored until the blanking time has run out.
          if (cnt_inc >= filt_cyc_i) begin
            next_state = ST_LOW;
            next_cnt = '0;
          end else begin
            next_cnt = cnt_inc;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_LOW;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign out_o = (state == ST_HIGH);

endmodule : rsh_edge_filter

// *** hw/rsh_sensor_cond.sv ***
// Digital conditioning behind the reluctance sensor zero-crossing comparator.
//
// Behaviour
// - Architecture select 1 picks architecture A, 0 picks architecture B.
// - Manual mode applies the programmed 3-bit level, codes above 4 as HI5, and holds it.
// - A adaptive mode sorts the input peak into five ranges by four thresholds.
// - Peak range below first threshold maps to HI1, above fourth to HI5.
// - A adaptive mode starts with HI3 after reset.
// - Peak logic follows the output before or after the filter, as selected.
// - Peak captured while the output is high sets the next level.
// - Hysteresis current on while output is low, off from its rising edge.
// - A filter time is the previous output period divided by 32.
// - A filter time clamps to 2.5 us below 80 us, starts at 125 us max.
// - Output rises only after input stays high longer than the filter time.
// - Falling filter bit 1 lowers output after input stays low filter time.
// - Falling filter bit 0 lowers output at once, then blanks filter time.
// - B manual new level applies after the second output falling edge.
// - Architecture B starts with HI1 after reset.
// - B limited-adaptive applies the larger of programmed and peak levels.
// - Limited-adaptive level applies after first fall, or second if bit set.
// - B minimum-force bit drives hysteresis to its lowest level.
// - B filter is fixed 2.5 us on both edges, 125 us after reset.
// - Architecture B offers the same two falling-edge strategies.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps

module rsh_sensor_cond #(
  parameter int CNT_W = rsh_pkg::CNT_W,
  parameter int FILT_START_CYC = rsh_pkg::FILT_START_CYC,
  parameter int PERIOD_SAT_CYC = rsh_pkg::PERIOD_SAT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [rsh_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic comp_i,
  input wire logic [rsh_pkg::PEAK_THR_N-1:0] peak_thr_i,
  output logic sensor_pulse_out_o,
  output logic hyst_on_o,
  output logic [2:0] hyst_level_o
);

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  localparam int SYNC_W = rsh_pkg::PEAK_THR_N + 1;

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic comp_s;
  logic [rsh_pkg::PEAK_THR_N-1:0] thr_s;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {peak_thr_i, comp_i};
      sync_b <= sync_a;
    end
  end

  assign comp_s = sync_b[0];
  assign thr_s = sync_b[SYNC_W-1:1];

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  logic [rsh_pkg::CFG_W-1:0] cfg;
  logic [rsh_pkg::CFG_W-1:0] next_cfg;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] filt_cyc;

  logic arch_a;
  logic hyst_adapt;
  logic filter_en;
  logic [2:0] hyst_level_field;
  logic peak_feedback_point;
  logic falling_edge_filter_sel;
  logic second_edge_apply;
  logic min_force;

  assign arch_a = cfg[rsh_pkg::CFG_ARCH_SELECT];
  assign hyst_adapt = cfg[rsh_pkg::CFG_HYST_ADAPT];
  assign filter_en = cfg[rsh_pkg::CFG_FILTER_EN];
  assign hyst_level_field = cfg[rsh_pkg::CFG_HYST_MSB:rsh_pkg::CFG_HYST_LSB];
  assign peak_feedback_point = cfg[rsh_pkg::CFG_PEAK_FB];
  assign falling_edge_filter_sel = cfg[rsh_pkg::CFG_FE_FILTER];
  assign second_edge_apply = cfg[rsh_pkg::CFG_SECOND_EDGE];
  assign min_force = cfg[rsh_pkg::CFG_MIN_FORCE];

  always_comb begin
    next_cfg = cfg;
    if (wr_i && (addr_i == rsh_pkg::ADDR_CFG)) begin
      next_cfg = wdata_i[rsh_pkg::CFG_W-1:0];
    end
    next_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        rsh_pkg::ADDR_CFG: next_rdata = {{(32 - rsh_pkg::CFG_W){1'b0}}, cfg};
        rsh_pkg::ADDR_STATUS: next_rdata = status_word;
        rsh_pkg::ADDR_PERIOD: next_rdata = {{(32 - CNT_W){1'b0}}, period};
        rsh_pkg::ADDR_FILTER: next_rdata = {{(32 - CNT_W){1'b0}}, filt_cyc};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg <= rsh_pkg::CFG_RESET;
      rdata_o <= '0;
    end else begin
      cfg <= next_cfg;
      rdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // Filter and period measurement
  // ---------------------------------------------------------------------
  logic pulse;
  logic pulse_q;
  logic pulse_rise;
  logic pulse_fall;
  logic period_valid;
  logic filt_seen;
  logic next_filt_seen;
  logic [CNT_W-1:0] next_filt_cyc;
  logic [CNT_W-1:0] period_div;

  rsh_edge_filter #(
    .CNT_W(CNT_W)
  ) u_filter (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .raw_i(comp_s),
    .en_i(filter_en),
    .fe_stable_i(falling_edge_filter_sel),
    .filt_cyc_i(filt_cyc),
    .out_o(pulse)
  );

  rsh_period_meter #(
    .CNT_W(CNT_W),
    .SAT_CYC(PERIOD_SAT_CYC)
  ) u_meter (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .rise_i(pulse_rise),
    .period_o(period),
    .valid_o(period_valid)
  );

  assign pulse_rise = pulse && !pulse_q;
  assign pulse_fall = !pulse && pulse_q;
  assign period_div = period >> rsh_pkg::FILT_DIV_SHIFT;

  // Filter time holds its start value until the first period is measured.
  always_comb begin
    next_filt_cyc = filt_cyc;
    next_filt_seen = filt_seen;
    if (period_valid) begin
      next_filt_seen = 1'b1;
      if (!arch_a) begin
        next_filt_cyc = CNT_W'(rsh_pkg::FILT_MIN_CYC);
      end else if (period < CNT_W'(rsh_pkg::PERIOD_MIN_CYC)) begin
        next_filt_cyc = CNT_W'(rsh_pkg::FILT_MIN_CYC);
      end else if (period_div > CNT_W'(FILT_START_CYC)) begin
        next_filt_cyc = CNT_W'(FILT_START_CYC);
      end else begin
        next_filt_cyc = period_div;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      filt_cyc <= CNT_W'(FILT_START_CYC);
      filt_seen <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      filt_cyc <= next_filt_cyc;
      filt_seen <= next_filt_seen;
      pulse_q <= pulse;
    end
  end

  // ---------------------------------------------------------------------
  // Peak detector
  // ---------------------------------------------------------------------
  logic peak_src;
  logic peak_src_q;
  logic [2:0] peak_now;
  logic [2:0] peak_max;
  logic [2:0] next_peak_max;
  logic [2:0] peak_lvl;
  logic [2:0] next_peak_lvl;
  logic peak_valid;
  logic next_peak_valid;

  // Thresholds rise in order, so the count of those exceeded is the range.
  always_comb begin
    peak_now = '0;
    for (int i = 0; i < rsh_pkg::PEAK_THR_N; i++) begin
      peak_now = peak_now + 3'(thr_s[i]);
    end
  end

  assign peak_src = peak_feedback_point ? pulse : comp_s;

  always_comb begin
    next_peak_max = peak_max;
    next_peak_lvl = peak_lvl;
    next_peak_valid = peak_valid;
    if (peak_src) begin
      if (peak_now > peak_max) begin
        next_peak_max = peak_now;
      end
    end else if (peak_src_q) begin
      next_peak_lvl = peak_max;
      next_peak_valid = 1'b1;
      next_peak_max = '0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      peak_src_q <= 1'b0;
      peak_max <= '0;
      peak_lvl <= '0;
      peak_valid <= 1'b0;
    end else begin
      peak_src_q <= peak_src;
      peak_max <= next_peak_max;
      peak_lvl <= next_peak_lvl;
      peak_valid <= next_peak_valid;
    end
  end

  // ---------------------------------------------------------------------
  // Hysteresis level selection
  // ---------------------------------------------------------------------
  logic [2:0] lvl;
  logic [2:0] next_lvl;
  logic [1:0] pend;
  logic [1:0] next_pend;
  logic [2:0] field_lvl;
  logic [2:0] target;
  logic [2:0] peak_b;
  logic [1:0] need;

  assign field_lvl = (hyst_level_field > rsh_pkg::HYST_LVL_5) ?
                     rsh_pkg::HYST_LVL_5 : hyst_level_field;
  assign peak_b = peak_valid ? peak_lvl : rsh_pkg::HYST_LVL_1;

  always_comb begin
    next_lvl = lvl;
    next_pend = pend;
    target = field_lvl;
    need = 2'd2;
    if (arch_a) begin
      next_pend = '0;
      if (min_force) begin
        target = rsh_pkg::HYST_LVL_3;
      end else if (hyst_adapt) begin
        target = peak_valid ? peak_lvl : rsh_pkg::HYST_LVL_3;
      end
      // Adaptive follows each new peak; manual waits for current off.
      if (hyst_adapt || min_force || pulse) begin
        next_lvl = target;
      end
    end else if (min_force) begin
      next_lvl = rsh_pkg::HYST_LVL_1;
      next_pend = '0;
    end else begin
      if (hyst_adapt) begin
        target = (peak_b > field_lvl) ? peak_b : field_lvl;
        need = second_edge_apply ? 2'd2 : 2'd1;
      end
      if (target == lvl) begin
        next_pend = '0;
      end else if (pulse_fall) begin
        if (pend + 2'd1 >= need) begin
          next_lvl = target;
          next_pend = '0;
        end else begin
          next_pend = pend + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl <= rsh_pkg::HYST_LVL_1;
      pend <= '0;
    end else begin
      lvl <= next_lvl;
      pend <= next_pend;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs and status
  // ---------------------------------------------------------------------
  assign sensor_pulse_out_o = pulse;
  assign hyst_on_o = !pulse;
  assign hyst_level_o = lvl;

  always_comb begin
    status_word = '0;
    status_word[rsh_pkg::ST_PULSE] = pulse;
    status_word[rsh_pkg::ST_HYST_ON] = !pulse;
    status_word[rsh_pkg::ST_LVL_MSB:rsh_pkg::ST_LVL_LSB] = lvl;
    status_word[rsh_pkg::ST_COMP] = comp_s;
    status_word[rsh_pkg::ST_PEAK_MSB:rsh_pkg::ST_PEAK_LSB] = peak_lvl;
    status_word[rsh_pkg::ST_PEAK_VALID] = peak_valid;
  end

endmodule : rsh_sensor_cond

// *** bench/rsh_sensor_model.sv ***
// Sensor model driving the comparator and peak threshold inputs.
`timescale 1ns/10ps

module rsh_sensor_model (
  input wire logic sys_clk_i,
  output logic comp_o,
  output logic [3:0] thr_o
);
  initial begin
    comp_o = 1'b0;
    thr_o = 4'h0;
  end

  // Peak comparators trip in ascending order, only on the positive swing.
  task automatic hi(input int n, input int pk);
    comp_o <= 1'b1;
    thr_o <= 4'((5'h01 << pk) - 5'h01);
    repeat (n) @(posedge sys_clk_i);
  endtask : hi

  task automatic lo(input int n);
    comp_o <= 1'b0;
    thr_o <= 4'h0;
    repeat (n) @(posedge sys_clk_i);
  endtask : lo
endmodule : rsh_sensor_model

// *** bench/rsh_sensor_cond_assertions.sv ***
// Port checker for the sensor conditioning block.
`timescale 1ns/10ps

module rsh_sensor_cond_chk #(
  parameter int CNT_W = rsh_pkg::CNT_W,
  parameter int FILT_START_CYC = rsh_pkg::FILT_START_CYC,
  parameter int PERIOD_SAT_CYC = rsh_pkg::PERIOD_SAT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [rsh_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic comp_i,
  input wire logic [rsh_pkg::PEAK_THR_N-1:0] peak_thr_i,
  input wire logic sensor_pulse_out_o,
  input wire logic hyst_on_o,
  input wire logic [2:0] hyst_level_o
);
  // Slack of four cycles covers the input synchroniser.
  localparam int RUN_MIN = rsh_pkg::FILT_MIN_CYC - 4;
  logic [9:0] cfg;
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic [2:0] man_lvl;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg <= rsh_pkg::CFG_RESET;
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h00;
    end else begin
      if (wr_i && addr_i == rsh_pkg::ADDR_CFG) begin
        cfg <= wdata_i[9:0];
      end
      hi_cnt <= !comp_i ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
      lo_cnt <= comp_i ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
    end
  end
  assign man_lvl = (cfg[5:3] > 3'h4) ? 3'h4 : cfg[5:3];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_raw_hi; (!cfg[2] && comp_i)[*4]; endsequence
  sequence s_raw_lo; (!cfg[2] && !comp_i)[*4]; endsequence

  property p_hyst_on; hyst_on_o != sensor_pulse_out_o; endproperty
  property p_level_max; hyst_level_o <= 3'h4; endproperty
  property p_reset_lvl;
    $fell(sys_rst_i) |-> hyst_level_o == rsh_pkg::HYST_LVL_1;
  endproperty
  property p_nofilt_rise; s_raw_hi |=> sensor_pulse_out_o; endproperty
  property p_nofilt_fall; s_raw_lo |=> !sensor_pulse_out_o; endproperty
  property p_rise_min;
    cfg[2] && $rose(sensor_pulse_out_o) |->
      $past(hi_cnt, 3) >= RUN_MIN || $past(hi_cnt, 4) >= RUN_MIN;
  endproperty
  property p_fe_stable;
    cfg[2] && cfg[7] && $fell(sensor_pulse_out_o) |->
      $past(lo_cnt, 3) >= RUN_MIN || $past(lo_cnt, 4) >= RUN_MIN;
  endproperty
  property p_fe_fast;
    (cfg[2] && !cfg[7] && sensor_pulse_out_o && !comp_i)[*4] |=>
      !sensor_pulse_out_o;
  endproperty
  property p_b_minforce;
    (!cfg[0] && cfg[9])[*3] |-> hyst_level_o == rsh_pkg::HYST_LVL_1;
  endproperty
  property p_a_manual;
    (cfg[0] && !cfg[1] && !cfg[9] && sensor_pulse_out_o)[*3] |->
      hyst_level_o == man_lvl;
  endproperty

  a_hyst_on: assert property (p_hyst_on)
    else $error("hysteresis enable not inverse of pulse");
  a_level_max: assert property (p_level_max)
    else $error("level above top code");
  a_reset_lvl: assert property (p_reset_lvl)
    else $error("level after reset not lowest");
  a_nofilt_rise: assert property (p_nofilt_rise)
    else $error("unfiltered rise late");
  a_nofilt_fall: assert property (p_nofilt_fall)
    else $error("unfiltered fall late");
  a_rise_min: assert property (p_rise_min)
    else $error("filtered rise too early");
  a_fe_stable: assert property (p_fe_stable)
    else $error("stable fall too early");
  a_fe_fast: assert property (p_fe_fast)
    else $error("immediate fall missing");
  a_b_minforce: assert property (p_b_minforce)
    else $error("minimum force ignored");
  a_a_manual: assert property (p_a_manual)
    else $error("manual level not applied");
endmodule : rsh_sensor_cond_chk

bind rsh_sensor_cond rsh_sensor_cond_chk #(.CNT_W(CNT_W),
  .FILT_START_CYC(FILT_START_CYC), .PERIOD_SAT_CYC(PERIOD_SAT_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .comp_i(comp_i), .peak_thr_i(peak_thr_i),
  .sensor_pulse_out_o(sensor_pulse_out_o), .hyst_on_o(hyst_on_o),
  .hyst_level_o(hyst_level_o));

// *** bench/test_reluctance_sensor_hyst_filter.sv ***
// Self-checking bench for the sensor conditioning block.
`timescale 1ns/10ps

module test_reluctance_sensor_hyst_filter;
  logic sys_clk_i;
  logic sys_rst_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic comp_i;
  logic [3:0] peak_thr_i;
  logic sensor_pulse_out_o;
  logic hyst_on_o;
  logic [2:0] hyst_level_o;
  int miscompares = 0;
  int comparisons = 0;
  int rises = 0;
  int r;
  int f;
  logic [9:0] cfg;

  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sensor_pulse_out_o) rises++;

  rsh_sensor_cond dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .comp_i(comp_i), .peak_thr_i(peak_thr_i),
    .sensor_pulse_out_o(sensor_pulse_out_o), .hyst_on_o(hyst_on_o),
    .hyst_level_o(hyst_level_o));
  rsh_sensor_model sens (.sys_clk_i(sys_clk_i), .comp_o(comp_i),
    .thr_o(peak_thr_i));

  function automatic logic [31:0] man_lvl(input int fld);
    return (fld > 4) ? 32'h4 : 32'(fld);
  endfunction : man_lvl

  function automatic logic [31:0] filt_exp(input int per);
    if (per < rsh_pkg::PERIOD_MIN_CYC) return 32'(rsh_pkg::FILT_MIN_CYC);
    if ((per >> 5) > rsh_pkg::FILT_START_CYC) begin
      return 32'(rsh_pkg::FILT_START_CYC);
    end
    return 32'(per >> 5);
  endfunction : filt_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic lvl(input logic [31:0] exp);
    chk(32'(hyst_level_o), exp);
  endtask : lvl

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    // Read data stand only between the next two rising edges.
    @(negedge sys_clk_i);
    chk(rdata_o, e);
    @(posedge sys_clk_i);
  endtask : rd_chk

  task automatic do_reset();
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : do_reset

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    sys_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    void'($urandom(94));
    do_reset();
    chk(32'(sensor_pulse_out_o), 32'h0);
    chk(32'(hyst_on_o), 32'h1);
    lvl(32'h0);
    rd_chk(rsh_pkg::ADDR_FILTER, 32'(rsh_pkg::FILT_START_CYC));
    rd_chk(rsh_pkg::ADDR_STATUS, 32'h0000_0002);
    rd_chk(8'h10, 32'h0);
    cfg = 10'($urandom());
    wr(rsh_pkg::ADDR_CFG, {22'h0, cfg});
    rd_chk(rsh_pkg::ADDR_CFG, {22'h0, cfg});
    // Manual level in B waits for the second falling output edge.
    wr(rsh_pkg::ADDR_CFG, 32'h0000_0018);
    sens.hi(20, 0);
    sens.lo(20);
    lvl(32'h0);
    sens.hi(20, 0);
    sens.lo(20);
    lvl(32'h3);
    wr(rsh_pkg::ADDR_CFG, 32'h0000_000A);
    sens.hi(20, 3);
    sens.lo(20);
    lvl(32'h3);
    wr(rsh_pkg::ADDR_CFG, 32'h0000_0122);
    sens.hi(20, 0);
    sens.lo(20);
    lvl(32'h3);
    sens.hi(20, 0);
    sens.lo(20);
    lvl(32'h4);
    wr(rsh_pkg::ADDR_CFG, 32'h0000_0322);
    repeat (3) @(posedge sys_clk_i);
    lvl(32'h0);
    for (int i = 0; i < 3; i++) begin
      f = $urandom_range(7);
      wr(rsh_pkg::ADDR_CFG, 32'((f << 3) | 1));
      sens.hi(20, 0);
      sens.lo(20);
      lvl(man_lvl(f));
    end
    do_reset();
    wr(rsh_pkg::ADDR_CFG, 32'(10'h003 | ($urandom_range(1) << 6)));
    repeat (3) @(posedge sys_clk_i);
    lvl(32'h2);
    r = $urandom_range(4);
    for (int k = 0; k < 5; k++) begin
      sens.hi(20, (k + r) % 5);
      sens.lo(20);
      lvl(32'((k + r) % 5));
    end
    // Adaptive filter: the first of two slow periods sets the filter time.
    wr(rsh_pkg::ADDR_CFG, 32'h0000_0085);
    sens.hi(6400, 0);
    sens.lo(6400);
    sens.hi(6400, 0);
    sens.lo(6400);
    rd_chk(rsh_pkg::ADDR_PERIOD, 32'h0000_3200);
    rd_chk(rsh_pkg::ADDR_FILTER, filt_exp(12800));
    for (int fe = 0; fe < 2; fe++) begin
      wr(rsh_pkg::ADDR_CFG, 32'((fe << 7) | 5));
      sens.hi(500, 0);
      sens.lo(5);
      chk(32'(sensor_pulse_out_o), 32'(fe));
      sens.lo(495);
    end
    r = rises;
    sens.hi(100, 0);
    sens.lo(200);
    chk(32'(rises), 32'(r));
    sens.hi(500, 0);
    sens.lo(500);
    rd_chk(rsh_pkg::ADDR_FILTER, filt_exp(1000));
    summarize();
  end
endmodule : test_reluctance_sensor_hyst_filter
